// ==== src/birtu_core.sv ====
// program counter control: interrupt return, long, block and relative jumps
`timescale 1ns/1ns
`default_nettype none

module birtu_core #(
  parameter int SP_W = 8
) (
  input  wire  logic                     CORE_CLK,
  input  wire  logic                     NRST,
  input  wire  logic                     START,
  input  wire  logic [7:0]               PROG_DATA,
  input  wire  logic [7:0]               STACK_POINTER,
  input  wire  logic [11:0]              STACK_DATA,
  input  wire  logic [7:0]               AUX_REGISTER_PAIR,
  input  wire  logic [7:0]               EXTENDED_ACCUMULATOR,
  output var   logic [14:0]              PROG_ADDR,
  output var   logic [7:0]               STACK_ADDR,
  output var   logic                     STACK_RD,
  output var   logic [7:0]               STACK_POINTER_NEW,
  output var   logic                     STACK_POINTER_LOAD,
  output var   logic                     INTERRUPT_LEVEL_HIGH,
  output var   logic                     INTERRUPT_LEVEL_LOW,
  output var   logic                     MEMORY_BANK_ENABLE_BIT,
  output var   logic                     REGISTER_BANK_ENABLE_BIT,
  output var   logic                     CARRY,
  output var   logic [2:0]               SKIP_CONDITION_BITS,
  output var   logic                     STATUS_LOAD,
  output var   logic                     BUSY,
  output var   logic                     DONE,
  output var   logic                     UNSUPPORTED
);

  // ==========================================================================
  // elaboration checks
  if (SP_W != 8)
  begin : g_sp_check
    $error("stack pointer width must be 8");
  end

  // ==========================================================================
  // state
  typedef struct packed {
    birtu_pkg::birtu_state_t state;
    logic [14:0]             pc;
    logic [7:0]              opcode;
    logic [14:0]             op_addr;
    logic [7:0]              sp;
    logic [7:0]              stack_addr;
    logic                    stack_rd;
    logic [11:0]             hold;
    logic [1:0]              level;
    logic                    mem_bank;
    logic                    reg_bank;
    logic                    carry;
    logic [2:0]              skip;
    logic [7:0]              sp_new;
    logic                    sp_load;
    logic                    status_load;
    logic                    busy;
    logic                    done;
    logic                    unsupported;
  } birtu_regs_t;

  birtu_regs_t r;
  birtu_regs_t next_r;

  logic [14:0] pc_plus1;
  logic [14:0] rel_fwd;
  logic [14:0] rel_back;
  logic [7:0]  index_val;
  logic [3:0]  low_nib;

  always_comb
  begin
    next_r             = r;
    next_r.done        = 1'b0;
    next_r.sp_load     = 1'b0;
    next_r.status_load = 1'b0;
    next_r.unsupported = 1'b0;
    pc_plus1           = r.pc + 15'h0001;
    low_nib            = r.opcode[3:0];
    rel_fwd            = r.op_addr + 15'h0001 + {11'h000, low_nib};
    rel_back           = r.op_addr - {11'h000, low_nib};
    index_val          = r.hold[0] ? AUX_REGISTER_PAIR : EXTENDED_ACCUMULATOR;
    case (r.state)
      birtu_pkg::ST_IDLE:
      begin
        if (START)
        begin
          next_r.opcode  = PROG_DATA;
          next_r.op_addr = r.pc;
          next_r.pc      = pc_plus1;
          next_r.busy    = 1'b1;
          next_r.sp      = STACK_POINTER;
          if (PROG_DATA == birtu_pkg::OP_INTERRUPT_RETURN)
          begin
            // busy holds off interrupt entry until the return has finished
            next_r.stack_addr = STACK_POINTER;
            next_r.stack_rd   = 1'b1;
            next_r.state      = birtu_pkg::ST_IRET1;
          end
          else if (PROG_DATA == birtu_pkg::OP_LONG_JUMP ||
                   PROG_DATA == birtu_pkg::OP_INDEXED_PREFIX ||
                   PROG_DATA[7:4] == birtu_pkg::OP_BLOCK_JUMP_HI)
          begin
            next_r.state = birtu_pkg::ST_FETCH2;
          end
          else if (PROG_DATA[7:4] == birtu_pkg::OP_REL_FORWARD_HI ||
                   PROG_DATA[7:4] == birtu_pkg::OP_REL_BACKWARD_HI)
          begin
            next_r.state = birtu_pkg::ST_REL;
          end
          else
          begin
            // not ours: counter untouched, the rest of the core handles it
            next_r.pc          = r.pc;
            next_r.busy        = 1'b0;
            next_r.unsupported = 1'b1;
          end
        end
      end
      birtu_pkg::ST_FETCH2:
      begin
        next_r.pc = pc_plus1;
        if (r.opcode == birtu_pkg::OP_LONG_JUMP)
        begin
          next_r.hold  = {4'h0, PROG_DATA};
          next_r.state = birtu_pkg::ST_FETCH3;
        end
        else if (r.opcode == birtu_pkg::OP_INDEXED_PREFIX)
        begin
          next_r.hold = {11'h000, PROG_DATA == birtu_pkg::OP2_INDEX_AUX};
          if (PROG_DATA == birtu_pkg::OP2_INDEX_AUX || PROG_DATA == birtu_pkg::OP2_INDEX_ACC)
          begin
            next_r.state = birtu_pkg::ST_FETCH3;
          end
          else
          begin
            next_r.pc          = r.op_addr;
            next_r.busy        = 1'b0;
            next_r.unsupported = 1'b1;
            next_r.state       = birtu_pkg::ST_IDLE;
          end
        end
        else
        begin
          // upper bits from the counter past both bytes, so the block edge carries
          next_r.pc    = {pc_plus1[14:12], r.opcode[3:0], PROG_DATA};
          next_r.busy  = 1'b0;
          next_r.done  = 1'b1;
          next_r.state = birtu_pkg::ST_IDLE;
        end
      end
      birtu_pkg::ST_FETCH3:
      begin
        if (r.opcode == birtu_pkg::OP_LONG_JUMP)
        begin
          next_r.pc = {1'b0, r.hold[5:0], PROG_DATA};
        end
        else
        begin
          // counter already sits past both bytes, the next page at a page end
          next_r.pc = {r.pc[14:8], index_val};
        end
        next_r.busy  = 1'b0;
        next_r.done  = 1'b1;
        next_r.state = birtu_pkg::ST_IDLE;
      end
      birtu_pkg::ST_REL:
      begin
        if (r.opcode[7:4] == birtu_pkg::OP_REL_FORWARD_HI)
        begin
          next_r.pc = rel_fwd;
        end
        else
        begin
          next_r.pc = rel_back;
        end
        next_r.busy  = 1'b0;
        next_r.done  = 1'b1;
        next_r.state = birtu_pkg::ST_IDLE;
      end
      birtu_pkg::ST_IRET1:
      begin
        next_r.hold       = STACK_DATA;
        next_r.stack_addr = r.sp + birtu_pkg::FRAME_HALF;
        next_r.state      = birtu_pkg::ST_IRET2;
      end
      birtu_pkg::ST_IRET2:
      begin
        // frame zeros and the missing bit 14 are never taken from memory
        next_r.pc          = {1'b0, r.hold[birtu_pkg::PC_TOP_LSB +: birtu_pkg::PC_TOP_W],
                              r.hold[birtu_pkg::NIB0_LSB +: birtu_pkg::NIB_W],
                              STACK_DATA[birtu_pkg::NIB0_LSB +: birtu_pkg::NIB_W],
                              r.hold[birtu_pkg::NIB2_LSB +: birtu_pkg::NIB_W]};
        next_r.level       = STACK_DATA[birtu_pkg::LEVEL_LSB +: 2];
        next_r.mem_bank    = STACK_DATA[birtu_pkg::MEM_BANK_BIT];
        next_r.reg_bank    = STACK_DATA[birtu_pkg::REG_BANK_BIT];
        next_r.carry       = STACK_DATA[birtu_pkg::CARRY_BIT];
        next_r.skip        = STACK_DATA[birtu_pkg::SKIP_LSB +: 3];
        next_r.status_load = 1'b1;
        next_r.sp_new      = r.sp + birtu_pkg::FRAME_SIZE;
        next_r.sp_load     = 1'b1;
        next_r.stack_rd    = 1'b0;
        next_r.busy        = 1'b0;
        next_r.done        = 1'b1;
        next_r.state       = birtu_pkg::ST_IDLE;
      end
      default:
      begin
        next_r.state    = birtu_pkg::ST_IDLE;
        next_r.busy     = 1'b0;
        next_r.stack_rd = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!NRST)
    begin
      r        <= '0;
      r.state  <= birtu_pkg::ST_IDLE;
      r.pc     <= birtu_pkg::PC_RESET;
      r.sp     <= birtu_pkg::SP_RESET;
      r.sp_new <= birtu_pkg::SP_RESET;
      r.opcode <= birtu_pkg::OP_RESET;
    end
    else
    begin
      r <= next_r;
    end
  end

  // ==========================================================================
  // outputs, all straight from the state register
  assign PROG_ADDR                = r.pc;
  assign STACK_ADDR               = r.stack_addr;
  assign STACK_RD                 = r.stack_rd;
  assign STACK_POINTER_NEW        = r.sp_new;
  assign STACK_POINTER_LOAD       = r.sp_load;
  assign INTERRUPT_LEVEL_HIGH     = r.level[1];
  assign INTERRUPT_LEVEL_LOW      = r.level[0];
  assign MEMORY_BANK_ENABLE_BIT   = r.mem_bank;
  assign REGISTER_BANK_ENABLE_BIT = r.reg_bank;
  assign CARRY                    = r.carry;
  assign SKIP_CONDITION_BITS      = r.skip;
  assign STATUS_LOAD              = r.status_load;
  assign BUSY                     = r.busy;
  assign DONE                     = r.done;
  assign UNSUPPORTED              = r.unsupported;

endmodule

`default_nettype wire

// ==== src/birtu_pkg.sv ====
// constants and types shared by the branch and interrupt return unit
`default_nettype none
package birtu_pkg;

  // ==========================================================================
  // widths
  localparam int PC_W      = 15;
  localparam int BYTE_W    = 8;
  localparam int NIB_W     = 4;
  localparam int FRAME_W   = 12;

  // ==========================================================================
  // opcodes of the first byte
  localparam logic [7:0] OP_INTERRUPT_RETURN = 8'hd5;
  localparam logic [7:0] OP_LONG_JUMP        = 8'hdb;
  localparam logic [7:0] OP_INDEXED_PREFIX   = 8'hdd;
  localparam logic [3:0] OP_BLOCK_JUMP_HI    = 4'h9;
  localparam logic [3:0] OP_REL_FORWARD_HI   = 4'h1;
  localparam logic [3:0] OP_REL_BACKWARD_HI  = 4'h0;
  // second byte of the indexed relative jumps
  localparam logic [7:0] OP2_INDEX_AUX       = 8'h64;
  localparam logic [7:0] OP2_INDEX_ACC       = 8'h60;

  // ==========================================================================
  // stack frame: step and nibble layout inside a three-nibble read
  localparam logic [7:0]  FRAME_SIZE       = 8'h06;
  localparam logic [7:0]  FRAME_HALF       = 8'h03;
  localparam int          NIB0_LSB         = 0;
  localparam int          NIB1_LSB         = 4;
  localparam int          NIB2_LSB         = 8;
  localparam int          PC_TOP_LSB       = 4;
  localparam int          PC_TOP_W         = 2;
  localparam int          LEVEL_LSB        = 6;
  localparam int          MEM_BANK_BIT     = 5;
  localparam int          REG_BANK_BIT     = 4;
  localparam int          CARRY_BIT        = 11;
  localparam int          SKIP_LSB         = 8;

  // ==========================================================================
  // reset values
  localparam logic [PC_W-1:0] PC_RESET  = 15'h0000;
  localparam logic [7:0]      SP_RESET  = 8'h00;
  localparam logic [7:0]      OP_RESET  = 8'h00;

  // ==========================================================================
  // sequencer states, gray on each forward step except ST_IDLE to ST_IRET1
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_FETCH2 = 3'b001,
    ST_FETCH3 = 3'b011,
    ST_REL    = 3'b010,
    ST_IRET1  = 3'b110,
    ST_IRET2  = 3'b111
  } birtu_state_t;

endpackage

`default_nettype wire

// ==== verification/birtu_core_monitor.sv ====
// concurrent checks on the ports of the branch and interrupt return unit
`timescale 1ns/1ns
`default_nettype none
module birtu_core_monitor (
  input wire logic        CORE_CLK,
  input wire logic        NRST,
  input wire logic        START,
  input wire logic [7:0]  PROG_DATA,
  input wire logic [7:0]  STACK_POINTER,
  input wire logic [11:0] STACK_DATA,
  input wire logic [7:0]  AUX_REGISTER_PAIR,
  input wire logic [7:0]  EXTENDED_ACCUMULATOR,
  input wire logic [14:0] PROG_ADDR,
  input wire logic [7:0]  STACK_ADDR,
  input wire logic        STACK_RD,
  input wire logic [7:0]  STACK_POINTER_NEW,
  input wire logic        STACK_POINTER_LOAD,
  input wire logic        INTERRUPT_LEVEL_HIGH,
  input wire logic        INTERRUPT_LEVEL_LOW,
  input wire logic        MEMORY_BANK_ENABLE_BIT,
  input wire logic        REGISTER_BANK_ENABLE_BIT,
  input wire logic        CARRY,
  input wire logic [2:0]  SKIP_CONDITION_BITS,
  input wire logic        STATUS_LOAD,
  input wire logic        BUSY,
  input wire logic        DONE
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!NRST);
  // ==========================================================================
  // helpers
  wire logic        take = START && !BUSY;
  wire logic [14:0] nxt  = PROG_ADDR + 15'h1;
  wire logic [7:0]  stat = {CARRY, SKIP_CONDITION_BITS, INTERRUPT_LEVEL_HIGH, INTERRUPT_LEVEL_LOW,
                            MEMORY_BANK_ENABLE_BIT, REGISTER_BANK_ENABLE_BIT};
  sequence s_interrupt_return_op_done;
    DONE && $past(take && PROG_DATA == birtu_pkg::OP_INTERRUPT_RETURN, 3);
  endsequence
  // ==========================================================================
  // properties
  property p_long_time;
    take && PROG_DATA == birtu_pkg::OP_LONG_JUMP |=> BUSY [*2] ##1 (DONE && !BUSY);
  endproperty
  a_long_time: assert property (p_long_time) else $error("long jump timing wrong");
  property p_long_pc;
    DONE && $past(take && PROG_DATA == birtu_pkg::OP_LONG_JUMP, 3)
      |-> PROG_ADDR == {1'b0, $past(PROG_DATA[5:0], 2), $past(PROG_DATA, 1)};
  endproperty
  a_long_pc: assert property (p_long_pc) else $error("long jump target wrong");
  property p_block_pc;
    DONE && $past(take && PROG_DATA[7:4] == birtu_pkg::OP_BLOCK_JUMP_HI, 2)
      |-> PROG_ADDR == {$past(nxt[14:12], 1), $past(PROG_DATA[3:0], 2), $past(PROG_DATA, 1)};
  endproperty
  a_block_pc: assert property (p_block_pc) else $error("block jump target wrong");
  property p_rel_time;
    take && PROG_DATA[7:5] == 3'h0 |=> BUSY ##1 (DONE && !BUSY);
  endproperty
  a_rel_time: assert property (p_rel_time) else $error("relative jump timing wrong");
  property p_fwd_pc;
    DONE && $past(take && PROG_DATA[7:4] == birtu_pkg::OP_REL_FORWARD_HI, 2)
      |-> PROG_ADDR == $past(PROG_ADDR, 2) + 15'h1 + $past(PROG_DATA[3:0], 2);
  endproperty
  a_fwd_pc: assert property (p_fwd_pc) else $error("forward jump target wrong");
  property p_back_pc;
    DONE && $past(take && PROG_DATA[7:4] == birtu_pkg::OP_REL_BACKWARD_HI, 2)
      |-> PROG_ADDR == $past(PROG_ADDR, 2) - $past(PROG_DATA[3:0], 2);
  endproperty
  a_back_pc: assert property (p_back_pc) else $error("backward jump target wrong");
  property p_idx_pc;
    DONE && $past(take && PROG_DATA == birtu_pkg::OP_INDEXED_PREFIX, 3)
      |-> PROG_ADDR == {$past(nxt[14:8], 2), ($past(PROG_DATA, 2) == birtu_pkg::OP2_INDEX_AUX ?
      $past(AUX_REGISTER_PAIR, 1) : $past(EXTENDED_ACCUMULATOR, 1))};
  endproperty
  a_idx_pc: assert property (p_idx_pc) else $error("indexed jump target wrong");
  property p_interrupt_return_op_time;
    take && PROG_DATA == birtu_pkg::OP_INTERRUPT_RETURN |=> (BUSY && STACK_RD && STACK_ADDR == $past(STACK_POINTER))
      ##1 (STACK_RD && STACK_ADDR == $past(STACK_POINTER, 2) + 8'h3) ##1 (DONE && !BUSY && !STACK_RD);
  endproperty
  a_interrupt_return_op_time: assert property (p_interrupt_return_op_time) else $error("return sequence wrong");
  property p_interrupt_return_op_pc;
    s_interrupt_return_op_done |-> STACK_POINTER_LOAD && STACK_POINTER_NEW == $past(STACK_POINTER, 3) + 8'h6
      && PROG_ADDR == {1'b0, $past(STACK_DATA[5:0], 2), $past(STACK_DATA[3:0], 1), $past(STACK_DATA[11:8], 2)};
  endproperty
  a_interrupt_return_op_pc: assert property (p_interrupt_return_op_pc) else $error("return address wrong");
  property p_interrupt_return_op_stat;
    s_interrupt_return_op_done |-> STATUS_LOAD && stat == $past(STACK_DATA[11:4], 1);
  endproperty
  a_interrupt_return_op_stat: assert property (p_interrupt_return_op_stat) else $error("status restore wrong");
  c_interrupt_return_op: cover property (s_interrupt_return_op_done);
  c_block: cover property (DONE && $past(take && PROG_DATA[7:4] == birtu_pkg::OP_BLOCK_JUMP_HI, 2));
  c_idx: cover property (take && PROG_DATA == birtu_pkg::OP_INDEXED_PREFIX);
endmodule
bind birtu_core birtu_core_monitor birtu_core_monitor_inst (.*);
`default_nettype wire

// ==== verification/birtu_mem_model.sv ====
// program memory and interrupt stack on the far side of the unit
`timescale 1ns/1ns
`default_nettype none
module birtu_mem_model (
  input  wire logic        clk,
  input  wire logic [14:0] prog_addr,
  output logic [7:0]       prog_data,
  input  wire logic [7:0]  stack_addr,
  input  wire logic        stack_rd,
  output logic [11:0]      stack_data
);
  logic [7:0] prog [0:32767];
  logic [3:0] stk  [0:255];
  logic       flip = 1'b0;
  always @(posedge clk)
    flip <= ~flip;
  assign prog_data = prog[prog_addr];
  // idle stack bus toggles so a stale read cannot match by luck
  assign stack_data = stack_rd ? {stk[stack_addr + 8'h2], stk[stack_addr + 8'h1], stk[stack_addr]} : {6{flip, ~flip}};
endmodule
`default_nettype wire

// ==== verification/birtu_bench.sv ====
// self-checking bench for the branch and interrupt return unit
`timescale 1ns/1ns
`default_nettype none
module birtu_bench;
  typedef struct packed {logic [14:0] a; logic [23:0] op; logic [3:0] n; logic [14:0] t;} birtu_row_t;
  // ==========================================================================
  // cases: address, bytes, cycles, landing address
  localparam birtu_row_t ROWS [14] = '{
    '{15'h0123, 24'hdb07ff, 4'h3, 15'h07ff}, '{15'h07ff, 24'hdb3fff, 4'h3, 15'h3fff},
    '{15'h0eab, 24'h90ff00, 4'h2, 15'h00ff}, '{15'h0ffe, 24'h90ff00, 4'h2, 15'h10ff},
    '{15'h0fff, 24'h9abc00, 4'h2, 15'h1abc}, '{15'h0200, 24'h1f0000, 4'h2, 15'h0210},
    '{15'h0250, 24'h110000, 4'h2, 15'h0252}, '{15'h0200, 24'h0f0000, 4'h2, 15'h01f1},
    '{15'h0300, 24'h010000, 4'h2, 15'h02ff}, '{15'h0300, 24'hdd6400, 4'h3, 15'h035a},
    '{15'h03fe, 24'hdd6000, 4'h3, 15'h043c}, '{15'h03ff, 24'hdd6400, 4'h3, 15'h045a},
    '{15'h0400, 24'hff0000, 4'h1, 15'h0400}, '{15'h0500, 24'hdd0000, 4'h2, 15'h0500}};
  logic        clk, nrst, start, srd, spl, ilh, ill, mbe, rbe, cy, stl, busy, done, uns;
  logic [7:0]  aux, acc, sp, pd, sa, sp_new;
  logic [11:0] sd;
  logic [14:0] pa;
  logic [2:0]  skip;
  int          errors = 0;
  int          checks = 0;
  birtu_core birtu_core_inst (.CORE_CLK(clk), .NRST(nrst), .START(start), .PROG_DATA(pd), .STACK_POINTER(sp),
    .STACK_DATA(sd), .AUX_REGISTER_PAIR(aux), .EXTENDED_ACCUMULATOR(acc), .PROG_ADDR(pa), .STACK_ADDR(sa),
    .STACK_RD(srd), .STACK_POINTER_NEW(sp_new), .STACK_POINTER_LOAD(spl), .INTERRUPT_LEVEL_HIGH(ilh),
    .INTERRUPT_LEVEL_LOW(ill), .MEMORY_BANK_ENABLE_BIT(mbe), .REGISTER_BANK_ENABLE_BIT(rbe), .CARRY(cy),
    .SKIP_CONDITION_BITS(skip), .STATUS_LOAD(stl), .BUSY(busy), .DONE(done), .UNSUPPORTED(uns));
  birtu_mem_model birtu_mem_model_inst (.clk(clk), .prog_addr(pa), .prog_data(pd), .stack_addr(sa),
    .stack_rd(srd), .stack_data(sd));
  // ==========================================================================
  // tasks
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // entered at a falling edge; next start lands in the done cycle, back to back
  task automatic run(input logic [23:0] op, input logic [3:0] n, input logic [14:0] t);
    logic [3:0] cnt;
    for (int i = 0; i < 3; i++)
      birtu_mem_model_inst.prog[pa + i] = op[23 - 8 * i -: 8];
    start = 1'b1;
    @(negedge clk);
    // a one-cycle refusal is already over: start stays up for the next call
    if (uns !== 1'b1)
      start = 1'b0;
    cnt = 4'h1;
    while (done !== 1'b1 && uns !== 1'b1 && cnt < 4'h8)
    begin
      @(negedge clk);
      cnt++;
    end
    check("cycles", {12'h0, cnt}, {12'h0, n});
    check("target", {1'b0, pa}, {1'b0, t});
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================================================
  // stimulus
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    repeat (1000) @(posedge clk);
    errors++;
    give_verdict();
  end
  initial
  begin
    nrst = 1'b0;
    start = 1'b0;
    aux = 8'h5a;
    acc = 8'h3c;
    sp = 8'hfa;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    foreach (ROWS[i])
    begin
      run({8'hdb, 2'b00, ROWS[i].a[13:0]}, 4'h3, ROWS[i].a);
      run(ROWS[i].op, ROWS[i].n, ROWS[i].t);
    end
    // second frame nibble carries ones in its top two bits that must be dropped
    {birtu_mem_model_inst.stk[250], birtu_mem_model_inst.stk[251], birtu_mem_model_inst.stk[252]} = 12'h1d3;
    {birtu_mem_model_inst.stk[253], birtu_mem_model_inst.stk[254], birtu_mem_model_inst.stk[255]} = 12'h2bd;
    run(24'hd50000, 4'h3, 15'h1123);
    check("status", {8'h0, cy, skip, ilh, ill, mbe, rbe}, 16'h00db);
    check("stack pointer", {6'h0, spl, stl, sp_new}, 16'h0300);
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    check("reset", {busy, pa}, 16'h0000);
    check("reset status", {6'h0, spl, stl, cy, skip, ilh, ill, mbe, rbe}, 16'h0000);
    nrst = 1'b1;
    run(24'h120000, 4'h2, 15'h0003);
    // start held through a whole jump must not restart it while busy
    {birtu_mem_model_inst.prog[3], birtu_mem_model_inst.prog[4], birtu_mem_model_inst.prog[5]} = 24'hdb0123;
    start = 1'b1;
    repeat (3) @(negedge clk);
    start = 1'b0;
    check("start while busy", {done, pa}, 16'h8123);
    give_verdict();
  end
endmodule
`default_nettype wire
